// file: hw/voltage_dac_regs.svh
// Register offsets, field positions and reset values of the level converter.
`ifndef VOLTAGE_DAC_REGS_SVH
`define VOLTAGE_DAC_REGS_SVH
`define ADDR_W          4
`define OFF_CTRL0       4'h0
`define OFF_CTRL1       4'h1
`define OFF_PIN_STATE   4'h2
`define BIT_ENABLE      7
`define BIT_PIN1_OE     5
`define BIT_PIN2_OE     4
`define BIT_PSS_HI      3
`define BIT_PSS_LO      2
`define BIT_NSS         0
`define CODE_HI         4
`define CTRL0_RST       8'h00
`define CTRL1_RST       8'h00
`define SYNC_RST        2'h0
`define RDATA_RST       8'h00
`define CTRL0_WMASK     8'hBD
`define CTRL1_WMASK     8'h1F
`define PSS_SUPPLY      2'h0
`define PSS_EXT_PIN     2'h1
`define PSS_FIXED       2'h2
`define PSS_RESERVED    2'h3
`define LEVEL_DIV       6'h20
`endif

// file: hw/voltage_dac_pkg.sv
// Types shared by the level converter control logic.
package voltage_dac_pkg;
  typedef enum logic [1:0] {
    pos_supply,
    pos_ext_pin,
    pos_fixed,
    pos_reserved
  } pos_ref_t;

  typedef struct packed {
    logic       converter_enable;
    logic       pin1_output_enable;
    logic       pin2_output_enable;
    pos_ref_t   positive_ref_select;
    logic       negative_ref_select;
    logic [4:0] level_code;
  } ladder_ctrl_t;

  typedef struct packed {
    logic out_driver_override;
    logic in_detector_override;
    logic pullup_disable;
  } pin_override_t;
endpackage : voltage_dac_pkg

// file: hw/voltage_dac_control.sv
// Control registers and analog steering of the 5-bit level converter.
`timescale 1ns/100ps
`include "voltage_dac_regs.svh"
`default_nettype none

module voltage_dac_control
  import voltage_dac_pkg::*;
#(
  parameter int ADDR_W = `ADDR_W
) (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              sleep_mode,
  input  wire logic              pin1_digital_in,
  input  wire logic              pin2_digital_in,
  output logic                   pin1_digital_read,
  output logic                   pin2_digital_read,
  output ladder_ctrl_t           ladder_ctrl,
  output pin_override_t          pin1_override,
  output pin_override_t          pin2_override,
  output logic                   level_to_comparator,
  output logic                   level_to_adc,
  output logic                   ref_pos_supply_sel,
  output logic                   ref_pos_ext_sel,
  output logic                   ref_pos_fixed_sel,
  output logic                   ref_neg_ext_sel,
  output logic                   ref_neg_ground_sel
);

  // The control registers; unimplemented bits are never stored.
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [7:0] next_ctrl0;
  logic [7:0] next_ctrl1;
  logic [7:0] next_rdata;

  // Pin inputs come from outside the clock domain.
  logic [1:0] pin1_sync;
  logic [1:0] pin2_sync;

  wire logic hit_ctrl0 = (reg_addr == ADDR_W'(`OFF_CTRL0));
  wire logic hit_ctrl1 = (reg_addr == ADDR_W'(`OFF_CTRL1));
  wire logic hit_pins  = (reg_addr == ADDR_W'(`OFF_PIN_STATE));
  wire logic wr_ctrl0  = reg_wr && hit_ctrl0;
  wire logic wr_ctrl1  = reg_wr && hit_ctrl1;

  // Sleep is deliberately not an input to the write path: the settings and
  // the ladder keep running unchanged through sleep and wake-up.
  assign next_ctrl0 = wr_ctrl0 ? (reg_wdata & `CTRL0_WMASK) : ctrl0;
  assign next_ctrl1 = wr_ctrl1 ? (reg_wdata & `CTRL1_WMASK) : ctrl1;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0 <= `CTRL0_RST;
      ctrl1 <= `CTRL1_RST;
    end else begin
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin1_sync <= `SYNC_RST;
      pin2_sync <= `SYNC_RST;
    end else begin
      pin1_sync <= {pin1_sync[0], pin1_digital_in};
      pin2_sync <= {pin2_sync[0], pin2_digital_in};
    end
  end

  // Field decode of the stored registers.
  wire logic       en      = ctrl0[`BIT_ENABLE];
  wire logic       oe1     = ctrl0[`BIT_PIN1_OE];
  wire logic       oe2     = ctrl0[`BIT_PIN2_OE];
  wire logic [1:0] pss     = ctrl0[`BIT_PSS_HI:`BIT_PSS_LO];
  wire logic       nss     = ctrl0[`BIT_NSS];
  wire logic [4:0] code    = ctrl1[`CODE_HI:0];
  wire logic [7:0] pin_rd  = {6'h00, pin2_digital_read, pin1_digital_read};

  // The ladder computes Vneg + (Vpos - Vneg) * code / 32 in the analog
  // domain; this block only hands it the code and reference switches.
  assign ladder_ctrl.converter_enable    = en;
  assign ladder_ctrl.pin1_output_enable  = oe1;
  assign ladder_ctrl.pin2_output_enable  = oe2;
  assign ladder_ctrl.positive_ref_select = pos_ref_t'(pss);
  assign ladder_ctrl.negative_ref_select = nss;
  assign ladder_ctrl.level_code          = code;

  // The reserved code 11 closes no positive switch, so no two references
  // can ever be shorted together through the ladder.
  assign ref_pos_supply_sel = en && (pss == `PSS_SUPPLY);
  assign ref_pos_ext_sel    = en && (pss == `PSS_EXT_PIN);
  assign ref_pos_fixed_sel  = en && (pss == `PSS_FIXED);
  assign ref_neg_ext_sel    = en && nss;
  assign ref_neg_ground_sel = en && !nss;

  // The level always feeds the internal consumers while enabled.
  assign level_to_comparator = en;
  assign level_to_adc        = en;

  // Pin overrides follow the pin enables regardless of sleep.
  assign pin1_override = '{oe1, oe1, oe1};
  assign pin2_override = '{oe2, oe2, oe2};
  assign pin1_digital_read = oe1 ? 1'b0 : pin1_sync[1];
  assign pin2_digital_read = oe2 ? 1'b0 : pin2_sync[1];

  // Read mux; unmapped addresses return zero.
  assign next_rdata = !reg_rd   ? 8'h00 :
                      hit_ctrl0 ? (ctrl0 & `CTRL0_WMASK) :
                      hit_ctrl1 ? (ctrl1 & `CTRL1_WMASK) :
                      hit_pins  ? pin_rd : 8'h00;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `RDATA_RST;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Assertions. The reset checks carry no disable, so that they also see
  // the edges at which reset is still held low.
  reset_ctrl0_a: assert property (
    @(posedge clk_sys)
    !arst_n |-> ctrl0 == `CTRL0_RST)
    else $error("control register 0 not cleared by reset");

  reset_ctrl1_a: assert property (
    @(posedge clk_sys)
    !arst_n |-> ctrl1 == `CTRL1_RST)
    else $error("level code not cleared by reset");

  reset_pins_a: assert property (
    @(posedge clk_sys)
    !arst_n |-> !ladder_ctrl.pin1_output_enable &&
                !ladder_ctrl.pin2_output_enable)
    else $error("pins still connected during reset");

  ctrl0_write_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    wr_ctrl0 |=>
      ladder_ctrl.converter_enable == $past(reg_wdata[`BIT_ENABLE]))
    else $error("enable did not follow write");

  code_write_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    wr_ctrl1 |=> ladder_ctrl.level_code == $past(reg_wdata[`CODE_HI:0]))
    else $error("level code did not follow write");

  pin_connect_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    wr_ctrl0 |=>
      pin1_override.pullup_disable == $past(reg_wdata[`BIT_PIN1_OE]) &&
      pin2_override.pullup_disable == $past(reg_wdata[`BIT_PIN2_OE]))
    else $error("pin enable mismatch");

  pin_read_zero_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    oe1 |-> !pin1_digital_read)
    else $error("converter pin 1 read not zero");

  pin2_read_zero_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    oe2 |-> !pin2_digital_read)
    else $error("converter pin 2 read not zero");

  pin1_pass_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !oe1 |-> pin1_digital_read == pin1_sync[1])
    else $error("pin 1 read does not follow the pin");

  pin2_pass_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !oe2 |-> pin2_digital_read == pin2_sync[1])
    else $error("pin 2 read does not follow the pin");

  pin1_override_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    pin1_override == {oe1, oe1, oe1})
    else $error("pin 1 override does not follow its enable");

  pin2_override_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    pin2_override == {oe2, oe2, oe2})
    else $error("pin 2 override does not follow its enable");

  pos_ref_onehot_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    $onehot0({ref_pos_supply_sel, ref_pos_ext_sel, ref_pos_fixed_sel}))
    else $error("two positive references closed");

  pos_closed_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    en && pss != `PSS_RESERVED |->
      $onehot({ref_pos_supply_sel, ref_pos_ext_sel, ref_pos_fixed_sel}))
    else $error("no positive reference closed");

  reserved_open_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    pss == `PSS_RESERVED |->
      !ref_pos_supply_sel && !ref_pos_ext_sel && !ref_pos_fixed_sel)
    else $error("reserved code closed a positive reference");

  ladder_sel_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    ladder_ctrl.positive_ref_select == pss &&
    ladder_ctrl.negative_ref_select == nss)
    else $error("reference selects not passed to the ladder");

  neg_ref_sel_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    en |-> (ref_neg_ext_sel != ref_neg_ground_sel))
    else $error("negative reference select wrong");

  neg_ground_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    en && !nss |-> ref_neg_ground_sel && !ref_neg_ext_sel)
    else $error("ground not selected as negative reference");

  off_no_switch_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !en |-> !(ref_pos_supply_sel || ref_pos_ext_sel || ref_pos_fixed_sel ||
              ref_neg_ext_sel || ref_neg_ground_sel))
    else $error("reference switch closed while disabled");

  level_code_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    ladder_ctrl.level_code == ctrl1[`CODE_HI:0])
    else $error("ladder code differs from stored code");

  ctrl0_read_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    reg_rd && hit_ctrl0 |=> (reg_rdata & ~`CTRL0_WMASK) == 8'h00)
    else $error("unimplemented ctrl0 bit nonzero");

  ctrl0_readback_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    reg_rd && hit_ctrl0 |=> reg_rdata == $past(ctrl0))
    else $error("ctrl0 read wrong");

  ctrl0_unused_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (ctrl0 & ~`CTRL0_WMASK) == 8'h00)
    else $error("unimplemented ctrl0 bit stored");

  ctrl1_read_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    reg_rd && hit_ctrl1 |=> (reg_rdata & ~`CTRL1_WMASK) == 8'h00 &&
                            reg_rdata[`CODE_HI:0] == $past(code))
    else $error("ctrl1 read wrong");

  ctrl1_unused_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (ctrl1 & ~`CTRL1_WMASK) == 8'h00)
    else $error("unimplemented ctrl1 bit stored");

  ctrl0_store_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    wr_ctrl0 |=> ctrl0 == ($past(reg_wdata) & `CTRL0_WMASK))
    else $error("ctrl0 write not stored");

  ctrl1_store_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    wr_ctrl1 |=> ctrl1 == ($past(reg_wdata) & `CTRL1_WMASK))
    else $error("ctrl1 write not stored");

  sleep_write_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    sleep_mode && wr_ctrl1 |=>
      ctrl1 == ($past(reg_wdata) & `CTRL1_WMASK))
    else $error("write lost during sleep");

  sleep_hold_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    sleep_mode && !reg_wr |=> $stable(ctrl0) && $stable(ctrl1))
    else $error("settings moved in sleep");

  stable_ctrl_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !$past(reg_wr) |-> $stable(ladder_ctrl))
    else $error("ladder control changed without write");

  hold_ctrl0_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !wr_ctrl0 |=> $stable(ctrl0))
    else $error("ctrl0 changed without a write to it");

  hold_ctrl1_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !wr_ctrl1 |=> $stable(ctrl1))
    else $error("ctrl1 changed without a write to it");

  pin_state_read_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    reg_rd && hit_pins |=> reg_rdata == $past(pin_rd))
    else $error("pin state read wrong");

  route_level_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    level_to_comparator == en && level_to_adc == en)
    else $error("internal routing wrong");

  route_off_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !en |-> !level_to_comparator && !level_to_adc)
    else $error("level routed while disabled");

  enable_cov_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    wr_ctrl0 && reg_wdata[`BIT_ENABLE]);

  full_code_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    code == 5'h1F && en);

  both_pins_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    oe1 && oe2 && sleep_mode);

  reserved_code_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    en && pss == `PSS_RESERVED);

  pin_pass_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    !oe1 && pin1_digital_read);

endmodule : voltage_dac_control
`default_nettype wire

// file: tb/pin_ladder_model.sv
// Behavioural model of the resistor ladder, reference switches and pins.
`timescale 1ns/100ps
`default_nettype none
module pin_ladder_model
  import voltage_dac_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire ladder_ctrl_t ladder_ctrl,
  output logic              pin1_digital_in,
  output logic              pin2_digital_in,
  output int                level_mv
);
  int pos_mv;
  int neg_mv;
  // Pins toggle every cycle so a leaked input never reads as a steady zero.
  initial pin1_digital_in = 1'b1;
  initial pin2_digital_in = 1'b0;
  always @(posedge clk_sys) begin
    pin1_digital_in <= ~pin1_digital_in;
    pin2_digital_in <= ~pin2_digital_in;
  end
  assign pos_mv = ladder_ctrl.positive_ref_select == pos_ext_pin ? 2500 :
                  ladder_ctrl.positive_ref_select == pos_fixed ? 2048 : 3300;
  assign neg_mv = ladder_ctrl.negative_ref_select ? 500 : 0;
  assign level_mv = !ladder_ctrl.converter_enable ? 0 :
    neg_mv + (pos_mv - neg_mv) * ladder_ctrl.level_code / 32;
endmodule : pin_ladder_model
`default_nettype wire

// file: tb/testbench.sv
// Random and corner tests of the level converter control registers.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import voltage_dac_pkg::*;
;
  logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, c0, c1;
  logic sleep_mode = 1'b0, pin1_digital_in, pin2_digital_in;
  logic pin1_digital_read, pin2_digital_read, cmp, adc, s0, s1, s2, ne, ng;
  ladder_ctrl_t ladder_ctrl;
  pin_override_t pin1_override, pin2_override;
  logic [15:0] lfsr = 16'hF3DF;
  logic [1:0] h1, h2;
  int miscompares = 0, tests_run = 0, cycles = 0, level_mv;
  voltage_dac_control dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
    .pin1_digital_in(pin1_digital_in), .pin2_digital_in(pin2_digital_in),
    .pin1_digital_read(pin1_digital_read),
    .pin2_digital_read(pin2_digital_read), .ladder_ctrl(ladder_ctrl),
    .pin1_override(pin1_override), .pin2_override(pin2_override),
    .level_to_comparator(cmp), .level_to_adc(adc), .ref_pos_supply_sel(s0),
    .ref_pos_ext_sel(s1), .ref_pos_fixed_sel(s2), .ref_neg_ext_sel(ne),
    .ref_neg_ground_sel(ng));
  pin_ladder_model far (.clk_sys(clk_sys), .ladder_ctrl(ladder_ctrl),
    .pin1_digital_in(pin1_digital_in), .pin2_digital_in(pin2_digital_in),
    .level_mv(level_mv));
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      h1 <= 2'h0;
      h2 <= 2'h0;
    end else begin
      h1 <= {h1[0], pin1_digital_in};
      h2 <= {h2[0], pin2_digital_in};
    end
  end
  function automatic logic [15:0] next_rand(logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction : next_rand
  function automatic logic [23:0] expo(logic [7:0] a, logic [7:0] b);
    logic e;
    e = a[7];
    return {e, a[5], a[4], a[3:2], a[0], b[4:0], {3{a[5]}}, {3{a[4]}}, e, e,
            e && a[3:2] == 2'h0, e && a[3:2] == 2'h1, e && a[3:2] == 2'h2,
            e && a[0], e && !a[0]};
  endfunction : expo
  task automatic chk(logic [23:0] got, logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk({16'h0, reg_rdata}, {16'h0, exp});
    @(posedge clk_sys);
  endtask : rd
  task automatic chk_outs();
    chk({ladder_ctrl, pin1_override, pin2_override, cmp, adc, s0, s1, s2, ne,
         ng}, expo(c0, c1));
    chk({23'h0, pin1_digital_read}, {23'h0, c0[5] ? 1'b0 : h1[1]});
    chk({23'h0, pin2_digital_read}, {23'h0, c0[4] ? 1'b0 : h2[1]});
  endtask : chk_outs
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 42; i++) begin
      @(posedge clk_sys);
      lfsr = next_rand(next_rand(lfsr));
      c0 = i == 0 ? 8'hFF : lfsr[7:0];
      c1 = i == 0 ? 8'hFF : lfsr[15:8];
      if (i == 20) begin
        arst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
      end
      if (i == 0 || i == 20) begin
        c0 = 8'h00;
        c1 = 8'h00;
        chk_outs();
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        c0 = 8'hFF;
        c1 = 8'hFF;
      end
      wr(4'h0, c0);
      @(posedge clk_sys);
      wr(4'h1, c1);
      c0 = c0 & 8'hBD;
      c1 = c1 & 8'h1F;
      rd(4'h0, c0);
      rd(4'h1, c1);
      sleep_mode <= lfsr[3];
      repeat (3) @(posedge clk_sys);
      chk_outs();
      wr(4'hF, ~c0);
      rd(4'hF, 8'h00);
      rd(4'h0, c0);
      chk_outs();
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
